// File: verilog/bsc_control.sv
// branch, skip and compare control: program counter, stall timing and flag update
`timescale 1ns/1ps
`include "bsc_map.svh"

// Overview of operation
// - decrement, self-and, self-xor, fill ones in one cycle; fill touches no flag
// - relative jump and call go to pc+offset+1; jump 2, call 3 cycles, call pushes
// - pointer jump loads pc from Z, two cycles, flags unchanged
// - pointer call pushes return address, loads pc from Z, three cycles, no flags
// - compare-skip-equal skips next instruction on match; 1/2/3 cycles, no flags
// - compares subtract without writing; update Z,N,V,C,H in one cycle; borrow form also subtracts C
// - register bit skips test chosen bit, skip when condition holds, 1/2/3 cycles
// - I/O bit skips test chosen I/O bit, skip when condition holds, 1/2/3 cycles
// - flag branch to pc+offset+1 when chosen flag matches; 1 or 2 cycles
// - carry-set branches on C=1; carry-clear and same-or-higher on C=0
// - signed branches use N xor V: ge on zero, less on one
// - half-carry branches taken on H set or clear, 1 or 2 cycles
// - T-flag branches taken on T set or clear, 1 or 2 cycles
// - overflow branches taken on V set or clear, 1 or 2 cycles
// - interrupts-on branch taken when I is one, no flag change
module bsc_control #(
  parameter int PC_W  = 16,
  parameter int OFS_W = 12
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_b,
  input  wire logic             i_op_valid,
  input  wire bsc_pkg::bsc_op_t i_op,
  input  wire logic [7:0]       i_rd,
  input  wire logic [7:0]       i_rr,
  input  wire logic [7:0]       i_imm,
  input  wire logic [7:0]       i_io,
  input  wire logic [2:0]       i_bit_sel,
  input  wire logic [OFS_W-1:0] i_offset,
  input  wire logic [PC_W-1:0]  i_z,
  input  wire logic [PC_W-1:0]  i_stack_pc,
  input  wire logic             i_next_two_word,
  input  wire logic [7:0]       i_flags,
  output logic      [PC_W-1:0]  o_pc,
  output logic                  o_busy,
  output logic      [7:0]       o_result,
  output logic                  o_result_we,
  output logic      [7:0]       o_flags,
  output logic                  o_flags_we,
  output logic                  o_push,
  output logic      [PC_W-1:0]  o_push_addr,
  output logic                  o_pop
);

  function automatic logic [PC_W-1:0] rel_target(input logic [PC_W-1:0] pc, input logic [OFS_W-1:0] ofs);
    logic [PC_W-1:0] ext;
    ext        = {{(PC_W-OFS_W){ofs[OFS_W-1]}}, ofs};
    rel_target = pc + ext + {{(PC_W-1){1'b0}}, 1'b1};
  endfunction

  bsc_pkg::bsc_state_t state_q, state_d;
  logic [2:0]      cnt_q, cnt_d;
  logic [PC_W-1:0] pc_q, pc_d;
  logic            busy_q, busy_d;
  logic [7:0]      result_q, result_d;
  logic            result_we_q, result_we_d;
  logic [7:0]      flags_q, flags_d;
  logic            flags_we_q, flags_we_d;
  logic            push_q, push_d;
  logic [PC_W-1:0] push_addr_q, push_addr_d;
  logic            pop_q, pop_d;

  logic            take;
  logic            br_taken;
  logic            is_branch;
  logic            skip_hit;
  logic            is_skip;
  logic [2:0]      cycles;
  logic [PC_W-1:0] pc_inc;
  logic [PC_W-1:0] br_tgt;
  logic [7:0]      fu_result;
  logic            fu_result_we;
  logic [7:0]      fu_flags;
  logic            fu_flags_we;

  bsc_flag_unit u_flag (
    .i_op        (i_op),
    .i_rd        (i_rd),
    .i_rr        (i_rr),
    .i_imm       (i_imm),
    .i_flags     (i_flags),
    .o_result    (fu_result),
    .o_result_we (fu_result_we),
    .o_flags     (fu_flags),
    .o_flags_we  (fu_flags_we)
  );

  // branch and skip conditions
  always_comb begin
    br_taken  = 1'b0;
    is_branch = 1'b1;
    case (i_op)
      bsc_pkg::BSC_OP_BRANCH_FLAG_SET:       br_taken = i_flags[i_bit_sel];
      bsc_pkg::BSC_OP_BRANCH_FLAG_CLEAR:     br_taken = ~i_flags[i_bit_sel];
      bsc_pkg::BSC_OP_BRANCH_SAME_OR_HIGHER: br_taken = ~i_flags[`BSC_FLAG_C];
      bsc_pkg::BSC_OP_BRANCH_LOWER:          br_taken = i_flags[`BSC_FLAG_C];
      bsc_pkg::BSC_OP_BRANCH_SIGNED_GE:
        br_taken = ~(i_flags[`BSC_FLAG_N] ^ i_flags[`BSC_FLAG_V]);
      bsc_pkg::BSC_OP_BRANCH_SIGNED_LESS:
        br_taken = i_flags[`BSC_FLAG_N] ^ i_flags[`BSC_FLAG_V];
      bsc_pkg::BSC_OP_BRANCH_INTERRUPTS_ON:  br_taken = i_flags[`BSC_FLAG_I];
      default:                               is_branch = 1'b0;
    endcase
  end

  always_comb begin
    skip_hit = 1'b0;
    is_skip  = 1'b1;
    case (i_op)
      bsc_pkg::BSC_OP_COMPARE_SKIP_EQUAL: skip_hit = (i_rd == i_rr);
      bsc_pkg::BSC_OP_SKIP_REG_BIT_CLEAR: skip_hit = ~i_rr[i_bit_sel];
      bsc_pkg::BSC_OP_SKIP_REG_BIT_SET:   skip_hit = i_rr[i_bit_sel];
      bsc_pkg::BSC_OP_SKIP_IO_BIT_CLEAR:  skip_hit = ~i_io[i_bit_sel];
      bsc_pkg::BSC_OP_SKIP_IO_BIT_SET:    skip_hit = i_io[i_bit_sel];
      default:                            is_skip  = 1'b0;
    endcase
  end

  // new ops are refused while a multi-cycle op still owns the pipeline
  always_comb begin
    take   = i_op_valid && (state_q == bsc_pkg::BSC_ST_IDLE);
    pc_inc = pc_q + {{(PC_W-1){1'b0}}, 1'b1};
    br_tgt = rel_target(pc_q, i_offset);
  end

  always_comb begin
    state_d     = state_q;
    cnt_d       = cnt_q;
    pc_d        = pc_q;
    busy_d      = busy_q;
    result_d    = result_q;
    result_we_d = 1'b0;
    flags_d     = flags_q;
    flags_we_d  = 1'b0;
    push_d      = 1'b0;
    push_addr_d = push_addr_q;
    pop_d       = 1'b0;
    cycles      = `BSC_CYC_SINGLE;
    case (state_q)
      bsc_pkg::BSC_ST_IDLE: begin
        if (take) begin
          pc_d        = pc_inc;
          result_d    = fu_result;
          result_we_d = fu_result_we;
          flags_d     = fu_flags;
          flags_we_d  = fu_flags_we;
          case (i_op)
            bsc_pkg::BSC_OP_RELATIVE_JUMP: begin
              pc_d   = br_tgt;
              cycles = `BSC_CYC_JUMP;
            end
            bsc_pkg::BSC_OP_RELATIVE_SUBROUTINE_CALL: begin
              pc_d        = br_tgt;
              push_d      = 1'b1;
              push_addr_d = pc_inc;
              cycles      = `BSC_CYC_CALL;
            end
            bsc_pkg::BSC_OP_POINTER_JUMP: begin
              pc_d   = i_z;
              cycles = `BSC_CYC_JUMP;
            end
            bsc_pkg::BSC_OP_POINTER_SUBROUTINE_CALL: begin
              pc_d        = i_z;
              push_d      = 1'b1;
              push_addr_d = pc_inc;
              cycles      = `BSC_CYC_CALL;
            end
            bsc_pkg::BSC_OP_SUBROUTINE_EXIT: begin
              pc_d   = i_stack_pc;
              pop_d  = 1'b1;
              cycles = `BSC_CYC_RETURN;
            end
            bsc_pkg::BSC_OP_INTERRUPT_EXIT: begin
              pc_d                   = i_stack_pc;
              pop_d                  = 1'b1;
              flags_d                = i_flags;
              flags_d[`BSC_FLAG_I]   = 1'b1;
              flags_we_d             = 1'b1;
              cycles                 = `BSC_CYC_RETURN;
            end
            default: begin
              if (is_branch && br_taken) begin
                pc_d   = br_tgt;
                cycles = `BSC_CYC_BR_TAKEN;
              end else if (is_skip && skip_hit) begin
                // skipped length comes from the fetch stage's predecode of the next word
                pc_d   = pc_q + {{(PC_W-2){1'b0}}, (i_next_two_word ? `BSC_SKIP_TWO_WORD : `BSC_SKIP_ONE_WORD)};
                cycles = i_next_two_word ? `BSC_CYC_SKIP_TWO : `BSC_CYC_SKIP_ONE;
              end
            end
          endcase
          if (cycles != `BSC_CYC_SINGLE) begin
            state_d = bsc_pkg::BSC_ST_STALL;
            cnt_d   = cycles - 3'd1;
            busy_d  = 1'b1;
          end
        end
      end
      bsc_pkg::BSC_ST_STALL: begin
        cnt_d = cnt_q - 3'd1;
        if (cnt_q == 3'd1) begin
          state_d = bsc_pkg::BSC_ST_IDLE;
          busy_d  = 1'b0;
        end
      end
      default: begin
        state_d = bsc_pkg::BSC_ST_IDLE;
        busy_d  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      state_q     <= bsc_pkg::BSC_ST_IDLE;
      cnt_q       <= 3'h0;
      pc_q        <= '0;
      busy_q      <= 1'b0;
      result_q    <= `BSC_RESULT_RST;
      result_we_q <= 1'b0;
      flags_q     <= `BSC_FLAGS_RST;
      flags_we_q  <= 1'b0;
      push_q      <= 1'b0;
      push_addr_q <= '0;
      pop_q       <= 1'b0;
    end else begin
      state_q     <= state_d;
      cnt_q       <= cnt_d;
      pc_q        <= pc_d;
      busy_q      <= busy_d;
      result_q    <= result_d;
      result_we_q <= result_we_d;
      flags_q     <= flags_d;
      flags_we_q  <= flags_we_d;
      push_q      <= push_d;
      push_addr_q <= push_addr_d;
      pop_q       <= pop_d;
    end
  end

  always_comb begin
    o_pc        = pc_q;
    o_busy      = busy_q;
    o_result    = result_q;
    o_result_we = result_we_q;
    o_flags     = flags_q;
    o_flags_we  = flags_we_q;
    o_push      = push_q;
    o_push_addr = push_addr_q;
    o_pop       = pop_q;
  end

  AST_FILL_NO_FLAGS: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    take && i_op == bsc_pkg::BSC_OP_FILL_ONES_REGISTER |=> o_result_we && o_result == 8'hff && !o_flags_we && !o_busy)
    else $error("fill ones wrote flags or wrong value");

  AST_REL_JUMP_TIMING: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    take && i_op == bsc_pkg::BSC_OP_RELATIVE_JUMP |=> (o_pc == $past(br_tgt)) && o_busy ##1 !o_busy)
    else $error("relative jump target or timing wrong");

  AST_REL_CALL_PUSH: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    take && i_op == bsc_pkg::BSC_OP_RELATIVE_SUBROUTINE_CALL
      |=> o_push && (o_push_addr == $past(pc_inc)) ##0 o_busy[*2] ##1 !o_busy)
    else $error("relative call push or timing wrong");

  AST_PTR_JUMP: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    take && i_op == bsc_pkg::BSC_OP_POINTER_JUMP |=> o_pc == $past(i_z) && !o_flags_we ##1 !o_busy)
    else $error("pointer jump wrong");

  AST_PTR_CALL: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    take && i_op == bsc_pkg::BSC_OP_POINTER_SUBROUTINE_CALL |=> o_push && o_pc == $past(i_z) ##2 !o_busy ##0 !o_flags_we)
    else $error("pointer call wrong");

  AST_SKIP_TWO_WORD: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    take && is_skip && skip_hit && i_next_two_word |=> (o_pc == PC_W'($past(pc_q) + 3)) ##0 o_busy[*2] ##1 !o_busy)
    else $error("two-word skip wrong");

  AST_COMPARE_NO_WRITE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    take && i_op == bsc_pkg::BSC_OP_COMPARE |=> !o_result_we && o_flags_we && !o_busy)
    else $error("compare wrote a register");

  AST_BRANCH_NOT_TAKEN: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    take && is_branch && !br_taken |=> o_pc == PC_W'($past(pc_q) + 1) && !o_busy)
    else $error("untaken branch moved pc wrongly");

  AST_EXIT_TIMING: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    take && i_op == bsc_pkg::BSC_OP_INTERRUPT_EXIT
      |=> o_pop && o_flags_we && o_flags[7] ##0 o_busy[*3] ##1 !o_busy)
    else $error("interrupt exit wrong");

endmodule

// File: pkg/bsc_map.svh
// constants for the branch, skip and compare control block
`ifndef BSC_MAP_SVH
`define BSC_MAP_SVH

// status flag bit positions
`define BSC_FLAG_C 3'd0
`define BSC_FLAG_Z 3'd1
`define BSC_FLAG_N 3'd2
`define BSC_FLAG_V 3'd3
`define BSC_FLAG_S 3'd4
`define BSC_FLAG_H 3'd5
`define BSC_FLAG_T 3'd6
`define BSC_FLAG_I 3'd7

// cycle counts per operation class
`define BSC_CYC_SINGLE   3'd1
`define BSC_CYC_JUMP     3'd2
`define BSC_CYC_CALL     3'd3
`define BSC_CYC_RETURN   3'd4
`define BSC_CYC_BR_TAKEN 3'd2
`define BSC_CYC_SKIP_ONE 3'd2
`define BSC_CYC_SKIP_TWO 3'd3

// pc advance for a skip over a one-word or two-word instruction
`define BSC_SKIP_ONE_WORD 2'd2
`define BSC_SKIP_TWO_WORD 2'd3

// fill value and reset values
`define BSC_FILL_VALUE 8'hff
`define BSC_RESULT_RST 8'h00
`define BSC_FLAGS_RST  8'h00

`endif

// File: pkg/bsc_pkg.sv
// types for the branch, skip and compare control block
package bsc_pkg;

  typedef enum logic [5:0] {
    BSC_OP_NONE,
    BSC_OP_REDUCE_BY_ONE,
    BSC_OP_SELF_AND_TEST,
    BSC_OP_ZERO_REGISTER,
    BSC_OP_FILL_ONES_REGISTER,
    BSC_OP_RELATIVE_JUMP,
    BSC_OP_POINTER_JUMP,
    BSC_OP_RELATIVE_SUBROUTINE_CALL,
    BSC_OP_POINTER_SUBROUTINE_CALL,
    BSC_OP_SUBROUTINE_EXIT,
    BSC_OP_INTERRUPT_EXIT,
    BSC_OP_COMPARE_SKIP_EQUAL,
    BSC_OP_COMPARE,
    BSC_OP_COMPARE_WITH_BORROW,
    BSC_OP_COMPARE_IMMEDIATE,
    BSC_OP_SKIP_REG_BIT_CLEAR,
    BSC_OP_SKIP_REG_BIT_SET,
    BSC_OP_SKIP_IO_BIT_CLEAR,
    BSC_OP_SKIP_IO_BIT_SET,
    BSC_OP_BRANCH_FLAG_SET,
    BSC_OP_BRANCH_FLAG_CLEAR,
    BSC_OP_BRANCH_SAME_OR_HIGHER,
    BSC_OP_BRANCH_LOWER,
    BSC_OP_BRANCH_SIGNED_GE,
    BSC_OP_BRANCH_SIGNED_LESS,
    BSC_OP_BRANCH_INTERRUPTS_ON
  } bsc_op_t;

  typedef enum logic {
    BSC_ST_IDLE,
    BSC_ST_STALL
  } bsc_state_t;

endpackage

// File: verilog/bsc_flag_unit.sv
// single-register operations and compares: result and status flag update
`timescale 1ns/1ps
`include "bsc_map.svh"

module bsc_flag_unit (
  input  wire bsc_pkg::bsc_op_t i_op,
  input  wire logic [7:0]       i_rd,
  input  wire logic [7:0]       i_rr,
  input  wire logic [7:0]       i_imm,
  input  wire logic [7:0]       i_flags,
  output logic      [7:0]       o_result,
  output logic                  o_result_we,
  output logic      [7:0]       o_flags,
  output logic                  o_flags_we
);

  logic [7:0] sub_b;
  logic [7:0] diff;
  logic       borrow_in;

  always_comb begin
    sub_b     = (i_op == bsc_pkg::BSC_OP_COMPARE_IMMEDIATE) ? i_imm : i_rr;
    borrow_in = (i_op == bsc_pkg::BSC_OP_COMPARE_WITH_BORROW) ? i_flags[`BSC_FLAG_C] : 1'b0;
    diff      = i_rd - sub_b - {7'h00, borrow_in};
  end

  always_comb begin
    o_result    = i_rd;
    o_result_we = 1'b0;
    o_flags     = i_flags;
    o_flags_we  = 1'b0;
    case (i_op)
      bsc_pkg::BSC_OP_REDUCE_BY_ONE: begin
        o_result                = i_rd - 8'h01;
        o_result_we             = 1'b1;
        o_flags_we              = 1'b1;
        o_flags[`BSC_FLAG_Z]    = (o_result == 8'h00);
        o_flags[`BSC_FLAG_N]    = o_result[7];
        o_flags[`BSC_FLAG_V]    = (i_rd == 8'h80);
      end
      bsc_pkg::BSC_OP_SELF_AND_TEST: begin
        o_result                = i_rd & i_rd;
        o_result_we             = 1'b1;
        o_flags_we              = 1'b1;
        o_flags[`BSC_FLAG_Z]    = (o_result == 8'h00);
        o_flags[`BSC_FLAG_N]    = o_result[7];
        o_flags[`BSC_FLAG_V]    = 1'b0;
      end
      bsc_pkg::BSC_OP_ZERO_REGISTER: begin
        o_result                = i_rd ^ i_rd;
        o_result_we             = 1'b1;
        o_flags_we              = 1'b1;
        o_flags[`BSC_FLAG_Z]    = 1'b1;
        o_flags[`BSC_FLAG_N]    = 1'b0;
        o_flags[`BSC_FLAG_V]    = 1'b0;
      end
      bsc_pkg::BSC_OP_FILL_ONES_REGISTER: begin
        o_result    = `BSC_FILL_VALUE;
        o_result_we = 1'b1;
      end
      bsc_pkg::BSC_OP_COMPARE,
      bsc_pkg::BSC_OP_COMPARE_WITH_BORROW,
      bsc_pkg::BSC_OP_COMPARE_IMMEDIATE: begin
        // no register write: the difference only drives the flags
        o_flags_we           = 1'b1;
        o_flags[`BSC_FLAG_Z] = (diff == 8'h00);
        // borrow form keeps zero only if it was already set, so multi-byte compares chain
        if (i_op == bsc_pkg::BSC_OP_COMPARE_WITH_BORROW) begin
          o_flags[`BSC_FLAG_Z] = (diff == 8'h00) & i_flags[`BSC_FLAG_Z];
        end
        o_flags[`BSC_FLAG_N] = diff[7];
        o_flags[`BSC_FLAG_V] = (i_rd[7] & ~sub_b[7] & ~diff[7]) | (~i_rd[7] & sub_b[7] & diff[7]);
        o_flags[`BSC_FLAG_C] = (~i_rd[7] & sub_b[7]) | (sub_b[7] & diff[7]) | (diff[7] & ~i_rd[7]);
        o_flags[`BSC_FLAG_H] = (~i_rd[3] & sub_b[3]) | (sub_b[3] & diff[3]) | (diff[3] & ~i_rd[3]);
      end
      default: begin
        o_result_we = 1'b0;
      end
    endcase
  end

endmodule

// File: sim/bsc_far_model.sv
// far-side model: return stack and status flag register
`timescale 1ns/1ps
module bsc_far_model #(
  parameter int PC_W = 16
) (
  input  wire logic            i_clk,
  input  wire logic            i_rst_b,
  input  wire logic            i_push,
  input  wire logic [PC_W-1:0] i_push_addr,
  input  wire logic            i_pop,
  input  wire logic            i_flags_we,
  input  wire logic [7:0]      i_flags,
  input  wire logic            i_load,
  input  wire logic [7:0]      i_load_val,
  output logic      [PC_W-1:0] o_top,
  output logic      [7:0]      o_flags
);
  logic [PC_W-1:0] mem_q [16];
  logic [3:0]      depth_q;
  logic [PC_W-1:0] junk_q;
  logic [7:0]      flags_q;
  // empty stack shows a moving pattern so a stray pop never reads a lucky value
  assign o_top   = (depth_q != 4'h0) ? mem_q[depth_q - 4'h1] : junk_q;
  // new flags pass straight through so a back-to-back op sees them
  assign o_flags = i_load ? i_load_val : (i_flags_we ? i_flags : flags_q);
  always @(posedge i_clk) begin
    junk_q  <= ~junk_q;
    flags_q <= o_flags;
    if (!i_rst_b) begin
      depth_q <= 4'h0;
      flags_q <= 8'h00;
      junk_q  <= {PC_W{1'b0}};
    end else if (i_push) begin
      mem_q[depth_q] <= i_push_addr;
      depth_q        <= depth_q + 4'h1;
    end else if (i_pop && depth_q != 4'h0) begin
      depth_q <= depth_q - 4'h1;
    end
  end
endmodule

// File: sim/branch_skip_compare_control_test.sv
// self-checking bench for the branch, skip and compare control block
`timescale 1ns/1ps
`include "bsc_map.svh"
module branch_skip_compare_control_test;
  localparam int PC_W  = 16;
  localparam int OFS_W = 12;
  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic [2:0]      busy;
    logic [3:0]      pls;
    logic [7:0]      res;
    logic [7:0]      flg;
    logic [PC_W-1:0] ret;
  } bsc_note_t;
  logic             clk      = 1'b0;
  logic             rst_b    = 1'b0;
  logic             op_valid = 1'b0;
  bsc_pkg::bsc_op_t op       = bsc_pkg::BSC_OP_NONE;
  logic [7:0]       rd       = 8'h00;
  logic [7:0]       rr       = 8'h00;
  logic [7:0]       imm      = 8'h00;
  logic [7:0]       io       = 8'h00;
  logic [2:0]       bit_sel  = 3'h0;
  logic [OFS_W-1:0] offset   = 12'h000;
  logic [PC_W-1:0]  z        = 16'h0000;
  logic             two_word = 1'b0;
  logic             ld       = 1'b0;
  logic [7:0]       ld_val   = 8'h00;
  logic [PC_W-1:0]  stack_pc;
  logic [7:0]       flags;
  logic [PC_W-1:0]  pc;
  logic             busy;
  logic [7:0]       result;
  logic             result_we;
  logic [7:0]       new_flags;
  logic             flags_we;
  logic             push;
  logic [PC_W-1:0]  push_addr;
  logic             pop;
  int               mismatches = 0;
  int               checked    = 0;
  int               bcnt       = 0;
  logic [31:0]      seed       = 32'd59247;
  logic [PC_W-1:0]  pc_m       = 16'h0000;
  logic [7:0]       fl_m       = 8'h00;
  logic             took_q     = 1'b0;
  logic             act        = 1'b0;
  logic [PC_W-1:0]  stk_m [$];
  bsc_note_t        notes [$];
  bsc_note_t        cur;
  bsc_pkg::bsc_op_t sop [7] = '{bsc_pkg::BSC_OP_REDUCE_BY_ONE, bsc_pkg::BSC_OP_SELF_AND_TEST,
    bsc_pkg::BSC_OP_ZERO_REGISTER, bsc_pkg::BSC_OP_FILL_ONES_REGISTER, bsc_pkg::BSC_OP_COMPARE,
    bsc_pkg::BSC_OP_COMPARE_WITH_BORROW, bsc_pkg::BSC_OP_COMPARE_IMMEDIATE};
  bsc_pkg::bsc_op_t bop [5] = '{bsc_pkg::BSC_OP_BRANCH_SAME_OR_HIGHER, bsc_pkg::BSC_OP_BRANCH_LOWER,
    bsc_pkg::BSC_OP_BRANCH_SIGNED_GE, bsc_pkg::BSC_OP_BRANCH_SIGNED_LESS, bsc_pkg::BSC_OP_BRANCH_INTERRUPTS_ON};
  bsc_pkg::bsc_op_t kop [5] = '{bsc_pkg::BSC_OP_COMPARE_SKIP_EQUAL, bsc_pkg::BSC_OP_SKIP_REG_BIT_CLEAR,
    bsc_pkg::BSC_OP_SKIP_REG_BIT_SET, bsc_pkg::BSC_OP_SKIP_IO_BIT_CLEAR, bsc_pkg::BSC_OP_SKIP_IO_BIT_SET};

  always #20 clk = ~clk;

  bsc_control #(.PC_W(PC_W), .OFS_W(OFS_W)) i_bsc_control (
    .i_clk(clk), .i_rst_b(rst_b), .i_op_valid(op_valid), .i_op(op), .i_rd(rd), .i_rr(rr),
    .i_imm(imm), .i_io(io), .i_bit_sel(bit_sel), .i_offset(offset), .i_z(z), .i_stack_pc(stack_pc),
    .i_next_two_word(two_word), .i_flags(flags), .o_pc(pc), .o_busy(busy), .o_result(result),
    .o_result_we(result_we), .o_flags(new_flags), .o_flags_we(flags_we), .o_push(push),
    .o_push_addr(push_addr), .o_pop(pop));

  bsc_far_model #(.PC_W(PC_W)) i_bsc_far_model (
    .i_clk(clk), .i_rst_b(rst_b), .i_push(push), .i_push_addr(push_addr), .i_pop(pop),
    .i_flags_we(flags_we), .i_flags(new_flags), .i_load(ld), .i_load_val(ld_val),
    .o_top(stack_pc), .o_flags(flags));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [7:0] znv(input logic [7:0] f, input logic [7:0] r, input logic v);
    logic [7:0] g;
    g = f;
    g[`BSC_FLAG_Z] = (r == 8'h00);
    g[`BSC_FLAG_N] = r[7];
    g[`BSC_FLAG_V] = v;
    return g;
  endfunction

  function automatic logic [7:0] sub_fl(input logic [7:0] f, input logic [7:0] d, input logic [7:0] s, input logic bw);
    logic [7:0] r;
    logic [7:0] g;
    r = d - s - {7'h00, bw & f[`BSC_FLAG_C]};
    g = znv(f, r, (d[7] & ~s[7] & ~r[7]) | (~d[7] & s[7] & r[7]));
    g[`BSC_FLAG_C] = (~d[7] & s[7]) | (s[7] & r[7]) | (r[7] & ~d[7]);
    g[`BSC_FLAG_H] = (~d[3] & s[3]) | (s[3] & r[3]) | (r[3] & ~d[3]);
    if (bw) g[`BSC_FLAG_Z] = g[`BSC_FLAG_Z] & f[`BSC_FLAG_Z];
    return g;
  endfunction

  function automatic logic cond(input bsc_pkg::bsc_op_t o, input logic [7:0] d, input logic [7:0] s);
    case (o)
      bsc_pkg::BSC_OP_BRANCH_FLAG_SET:       return fl_m[bit_sel];
      bsc_pkg::BSC_OP_BRANCH_FLAG_CLEAR:     return !fl_m[bit_sel];
      bsc_pkg::BSC_OP_BRANCH_SAME_OR_HIGHER: return !fl_m[`BSC_FLAG_C];
      bsc_pkg::BSC_OP_BRANCH_LOWER:          return fl_m[`BSC_FLAG_C];
      bsc_pkg::BSC_OP_BRANCH_SIGNED_GE:      return !(fl_m[`BSC_FLAG_N] ^ fl_m[`BSC_FLAG_V]);
      bsc_pkg::BSC_OP_BRANCH_SIGNED_LESS:    return fl_m[`BSC_FLAG_N] ^ fl_m[`BSC_FLAG_V];
      bsc_pkg::BSC_OP_BRANCH_INTERRUPTS_ON:  return fl_m[`BSC_FLAG_I];
      bsc_pkg::BSC_OP_SKIP_REG_BIT_CLEAR:    return !s[bit_sel];
      bsc_pkg::BSC_OP_SKIP_REG_BIT_SET:      return s[bit_sel];
      bsc_pkg::BSC_OP_SKIP_IO_BIT_CLEAR:     return !io[bit_sel];
      bsc_pkg::BSC_OP_SKIP_IO_BIT_SET:       return io[bit_sel];
      default:                               return d == s;
    endcase
  endfunction

  task automatic chk(input logic [PC_W-1:0] got, input logic [PC_W-1:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic stop_test();
    if (mismatches == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic set_fl(input logic [7:0] v);
    fl_m     = v;
    op_valid = 1'b0;
    ld       = 1'b1;
    ld_val   = v;
    @(posedge clk);
    #1;
    ld = 1'b0;
  endtask

  // valid stays up with the old op while busy, so every stall also exercises refusal
  task automatic do_op(input bsc_pkg::bsc_op_t o, input logic [7:0] d, input logic [7:0] s, input logic [OFS_W-1:0] k);
    bsc_note_t       n;
    logic [PC_W-1:0] tgt;
    int              w;
    tgt   = pc_m + {{(PC_W-OFS_W){k[OFS_W-1]}}, k} + 16'h0001;
    n     = '0;
    n.pc  = pc_m + 16'h0001;
    n.flg = fl_m;
    n.ret = pc_m + 16'h0001;
    case (o)
      bsc_pkg::BSC_OP_REDUCE_BY_ONE, bsc_pkg::BSC_OP_SELF_AND_TEST, bsc_pkg::BSC_OP_ZERO_REGISTER: begin
        n.res = (o == bsc_pkg::BSC_OP_REDUCE_BY_ONE) ? d - 8'h01 : (o == bsc_pkg::BSC_OP_SELF_AND_TEST) ? d : 8'h00;
        n.flg = znv(fl_m, n.res, (o == bsc_pkg::BSC_OP_REDUCE_BY_ONE) && d == 8'h80);
        n.pls = 4'h3;
      end
      bsc_pkg::BSC_OP_FILL_ONES_REGISTER: begin
        n.res = `BSC_FILL_VALUE;
        n.pls = 4'h2;
      end
      bsc_pkg::BSC_OP_COMPARE, bsc_pkg::BSC_OP_COMPARE_WITH_BORROW, bsc_pkg::BSC_OP_COMPARE_IMMEDIATE: begin
        n.flg = sub_fl(fl_m, d, (o == bsc_pkg::BSC_OP_COMPARE_IMMEDIATE) ? imm : s, o == bsc_pkg::BSC_OP_COMPARE_WITH_BORROW);
        n.pls = 4'h1;
      end
      bsc_pkg::BSC_OP_RELATIVE_JUMP, bsc_pkg::BSC_OP_POINTER_JUMP: begin
        n.pc   = (o == bsc_pkg::BSC_OP_RELATIVE_JUMP) ? tgt : z;
        n.busy = `BSC_CYC_JUMP - 3'd1;
      end
      bsc_pkg::BSC_OP_RELATIVE_SUBROUTINE_CALL, bsc_pkg::BSC_OP_POINTER_SUBROUTINE_CALL: begin
        n.pc   = (o == bsc_pkg::BSC_OP_RELATIVE_SUBROUTINE_CALL) ? tgt : z;
        n.busy = `BSC_CYC_CALL - 3'd1;
        n.pls  = 4'h8;
        stk_m.push_back(n.ret);
      end
      bsc_pkg::BSC_OP_SUBROUTINE_EXIT, bsc_pkg::BSC_OP_INTERRUPT_EXIT: begin
        n.pc   = stk_m.pop_back();
        n.busy = `BSC_CYC_RETURN - 3'd1;
        n.pls  = (o == bsc_pkg::BSC_OP_INTERRUPT_EXIT) ? 4'h5 : 4'h4;
        n.flg  = (o == bsc_pkg::BSC_OP_INTERRUPT_EXIT) ? fl_m | 8'h80 : fl_m;
      end
      bsc_pkg::BSC_OP_NONE: n.pc = pc_m + 16'h0001;
      default: begin
        if (cond(o, d, s) && o >= bsc_pkg::BSC_OP_BRANCH_FLAG_SET) begin
          n.pc   = tgt;
          n.busy = `BSC_CYC_BR_TAKEN - 3'd1;
        end else if (cond(o, d, s)) begin
          n.pc   = pc_m + (two_word ? `BSC_SKIP_TWO_WORD : `BSC_SKIP_ONE_WORD);
          n.busy = two_word ? `BSC_CYC_SKIP_TWO - 3'd1 : `BSC_CYC_SKIP_ONE - 3'd1;
        end
      end
    endcase
    pc_m = n.pc;
    fl_m = n.flg;
    notes.push_back(n);
    op       = o;
    rd       = d;
    rr       = s;
    offset   = k;
    op_valid = 1'b1;
    @(posedge clk);
    #1;
    w = 0;
    while (busy === 1'b1 && w < 10) begin
      @(posedge clk);
      #1;
      w++;
    end
  endtask

  always @(posedge clk) took_q <= rst_b & op_valid & (busy === 1'b0);

  always @(negedge clk) begin
    if (took_q) begin
      cur = notes.pop_front();
      chk(pc, cur.pc, "pc");
      chk({12'h000, push, pop, result_we, flags_we}, {12'h000, cur.pls}, "strobes");
      if (cur.pls[1]) chk({8'h00, result}, {8'h00, cur.res}, "result");
      if (cur.pls[0]) chk({8'h00, new_flags}, {8'h00, cur.flg}, "flags");
      if (cur.pls[3]) chk(push_addr, cur.ret, "return address");
      bcnt = 0;
      act  = 1'b1;
    end
    if (act) begin
      if (busy === 1'b1) bcnt++;
      else begin
        chk(bcnt[PC_W-1:0], {13'h0, cur.busy}, "stall length");
        act = 1'b0;
      end
    end
  end

  initial begin
    #(40 * 4000);
    mismatches++;
    stop_test();
  end

  initial begin
    logic [31:0] r;
    repeat (12) @(posedge clk);
    #1;
    rst_b = 1'b1;
    chk(pc, 16'h0000, "reset pc");
    chk({11'h0, busy, push, pop, result_we, flags_we}, 16'h0000, "reset strobes");
    set_fl(8'h00);
    do_op(bsc_pkg::BSC_OP_REDUCE_BY_ONE, 8'h80, 8'h00, 12'h000);
    do_op(bsc_pkg::BSC_OP_NONE, 8'h00, 8'h00, 12'h000);
    for (int i = 0; i < 42; i++) begin
      r   = rnd();
      imm = (i % 3 == 0) ? r[7:0] : r[31:24];
      do_op(sop[i % 7], r[7:0], (i % 3 == 0) ? r[7:0] : r[15:8], r[27:16]);
    end
    for (int i = 0; i < 16; i++) begin
      r       = rnd();
      bit_sel = i[2:0];
      set_fl(i[3] ? (r[7:0] | (8'h01 << i[2:0])) : (r[7:0] & ~(8'h01 << i[2:0])));
      do_op(bsc_pkg::BSC_OP_BRANCH_FLAG_SET, 8'h00, 8'h00, r[19:8]);
      do_op(bsc_pkg::BSC_OP_BRANCH_FLAG_CLEAR, 8'h00, 8'h00, r[31:20]);
    end
    for (int i = 0; i < 40; i++) begin
      r = rnd();
      set_fl(r[7:0]);
      do_op(bop[i % 5], 8'h00, 8'h00, r[19:8]);
    end
    for (int i = 0; i < 40; i++) begin
      r        = rnd();
      bit_sel  = r[2:0];
      two_word = r[3];
      io       = r[15:8];
      do_op(kop[i % 5], r[23:16], r[4] ? r[23:16] : r[31:24], 12'h000);
    end
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      z = r[15:0];
      do_op(bsc_pkg::BSC_OP_RELATIVE_SUBROUTINE_CALL, 8'h00, 8'h00, r[27:16]);
      do_op(bsc_pkg::BSC_OP_POINTER_SUBROUTINE_CALL, 8'h00, 8'h00, 12'h000);
      do_op(bsc_pkg::BSC_OP_SUBROUTINE_EXIT, 8'h00, 8'h00, 12'h000);
      do_op(bsc_pkg::BSC_OP_INTERRUPT_EXIT, 8'h00, 8'h00, 12'h000);
      do_op(bsc_pkg::BSC_OP_RELATIVE_JUMP, 8'h00, 8'h00, ~r[27:16]);
      do_op(bsc_pkg::BSC_OP_POINTER_JUMP, 8'h00, 8'h00, 12'h000);
    end
    op_valid = 1'b0;
    repeat (4) @(posedge clk);
    stop_test();
  end
endmodule
